// ---- logic/bcv_consts.svh ----
// Register indices, field positions and reset values of the converter register bank.
`ifndef BCV_CONSTS_SVH
`define BCV_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define BCV_IDX_IO_CFG 8'hA0
`define BCV_IDX_MEM_CFG 8'hA1
`define BCV_IDX_PERIPH_CFG 8'hA2
`define BCV_IDX_CORE_TWO_VA 8'hA3
`define BCV_IDX_CORE_ONE_VA 8'hA4

// Narrowest address bus that still reaches the highest byte address.
`define BCV_MIN_ADDR_W 10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BCV_OP_HI 7
`define BCV_OP_LO 6
`define BCV_PD_BIT 5
`define BCV_RSV_HI 4
`define BCV_RSV_LO 3
`define BCV_SENSE_HI 2
`define BCV_SENSE_LO 0
`define BCV_SLEEP_BIT 7
`define BCV_CODE_HI 6
`define BCV_CODE_LO 0

// Writable bits of a configuration register; bits 4:3 are reserved.
`define BCV_CFG_WMASK 8'hE7

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
// Mode from voltage register, pull-down on, own output sensed (a valid set).
`define BCV_CFG_RST 8'h01
// Synchronous operation, code 0x50 (1.10 V).
`define BCV_VOLT_RST 8'h50

`endif

// ---- logic/bcv_pkg.sv ----
// Types shared by the converter register bank and its mode decoder.
package bcv_pkg;

    // Operating-select field codes.
    typedef enum logic [1:0] {
        BCV_OP_FROM_VREG = 2'h0,
        BCV_OP_SLEEP = 2'h1,
        BCV_OP_SYNC = 2'h2,
        BCV_OP_AUTO = 2'h3
    } bcv_op_sel_t;

    // Operating style handed to the analog converter, one-hot.
    typedef enum logic [2:0] {
        BCV_STY_SLEEP = 3'h1,
        BCV_STY_SYNC = 3'h2,
        BCV_STY_AUTO = 3'h4
    } bcv_style_t;

endpackage

// ---- logic/bcv_mode_decode.sv ----
// Decoder from operating-select field and voltage-register sleep bit to operating style.
`timescale 1ns/10ps

module bcv_mode_decode
(
    // Settings
    input wire bcv_pkg::bcv_op_sel_t opSelect,
    input wire logic vregSleep,
    // Result
    output bcv_pkg::bcv_style_t style
);

    // Only the pass-through code looks at the voltage register; the others override it.
    always_comb
    begin
        unique case (opSelect)
            bcv_pkg::BCV_OP_FROM_VREG:
            begin
                style = vregSleep ? bcv_pkg::BCV_STY_SLEEP : bcv_pkg::BCV_STY_SYNC;
            end
            bcv_pkg::BCV_OP_SLEEP:
            begin
                style = bcv_pkg::BCV_STY_SLEEP;
            end
            bcv_pkg::BCV_OP_SYNC:
            begin
                style = bcv_pkg::BCV_STY_SYNC;
            end
            bcv_pkg::BCV_OP_AUTO:
            begin
                style = bcv_pkg::BCV_STY_AUTO;
            end
        endcase
    end

endmodule

// ---- logic/bcv_regs.sv ----
// APB register bank for the IO, memory and peripheral converter set-up and core A voltages.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "bcv_consts.svh"

// How it works
// - Select 00: voltage register sleep bit decides
// - Select 01: always sleep operation
// - Select 10 synchronous, 11 automatic
// - Bit 5 set removes output pull-down
// - Bits 2:0 pick feedback sources, any mix
// - Core A bit 7: sleep, else synchronous

module bcv_regs
#(
    parameter int ADDR_W = 12
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sleep bit of the currently selected A or B voltage register
    input wire logic ioVregSleep,
    input wire logic memVregSleep,
    input wire logic periphVregSleep,
    // IO converter controls
    output logic [1:0] ioConvOpSelect,
    output logic ioConvPulldownOff,
    output logic [2:0] ioConvSenseSelect,
    output logic [2:0] ioConvStyle,
    // Memory converter controls
    output logic [1:0] memConvOpSelect,
    output logic memConvPulldownOff,
    output logic [2:0] memConvSenseSelect,
    output logic [2:0] memConvStyle,
    // Peripheral converter controls
    output logic [1:0] periphConvOpSelect,
    output logic periphConvPulldownOff,
    output logic [2:0] periphConvSenseSelect,
    output logic [2:0] periphConvStyle,
    // Core converter A settings
    output logic coreOneSleepOnA,
    output logic [6:0] coreOneTargetCodeA,
    output logic coreTwoSleepOnA,
    output logic [6:0] coreTwoTargetCodeA
);

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    if (ADDR_W < `BCV_MIN_ADDR_W || ADDR_W > 32)
    begin : gBadAddrW
        $error("ADDR_W cannot reach the register map.");
    end

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    // Slot 0 is IO, 1 memory, 2 peripheral; voltage slot 0 is core two, 1 core one.
    logic [ADDR_W-3:0] wordIdx;
    logic [2:0] cfgHit;
    logic [1:0] voltHit;
    logic hit;
    logic [7:0] rdByte;
    logic wrEn;
    logic ack_q;
    logic ack_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic slverr_q;
    logic slverr_d;
    logic [7:0] cfgRegs_q [3];
    logic [7:0] cfgRegs_d [3];
    logic [7:0] coreVolt_q [2];
    logic [7:0] coreVolt_d [2];
    logic vregSleep [3];
    bcv_pkg::bcv_style_t styleNext [3];
    bcv_pkg::bcv_style_t style_q [3];
    bcv_pkg::bcv_style_t style_d [3];

    assign wordIdx = paddr[ADDR_W-1:2];
    assign vregSleep[0] = ioVregSleep;
    assign vregSleep[1] = memVregSleep;
    assign vregSleep[2] = periphVregSleep;

    // ------------------------------------------------------------------------
    // Address decode and read mux
    // ------------------------------------------------------------------------
    // Byte offset bits are ignored, so any byte of a word reaches its register.
    always_comb
    begin
        cfgHit = 3'h0;
        voltHit = 2'h0;
        case (wordIdx)
            (ADDR_W-2)'(`BCV_IDX_IO_CFG): cfgHit[0] = 1'h1;
            (ADDR_W-2)'(`BCV_IDX_MEM_CFG): cfgHit[1] = 1'h1;
            (ADDR_W-2)'(`BCV_IDX_PERIPH_CFG): cfgHit[2] = 1'h1;
            (ADDR_W-2)'(`BCV_IDX_CORE_TWO_VA): voltHit[0] = 1'h1;
            (ADDR_W-2)'(`BCV_IDX_CORE_ONE_VA): voltHit[1] = 1'h1;
            default: cfgHit = 3'h0;
        endcase
        hit = (|cfgHit) | (|voltHit);
    end

    // Reserved bits are never stored, so the plain register value reads them as zero.
    always_comb
    begin
        rdByte = 8'h00;
        for (int i = 0; i < 3; i++)
        begin
            if (cfgHit[i])
            begin
                rdByte = cfgRegs_q[i];
            end
        end
        for (int j = 0; j < 2; j++)
        begin
            if (voltHit[j])
            begin
                rdByte = coreVolt_q[j];
            end
        end
    end

    // ------------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------------
    // One wait state lets read data come from a flip-flop rather than the mux.
    always_comb
    begin
        ack_d = psel & penable & ~ack_q;
        prdata_d = prdata_q;
        slverr_d = 1'h0;
        if (ack_d)
        begin
            prdata_d = {24'h000000, rdByte};
            slverr_d = ~hit;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ack_q <= 1'h0;
            prdata_q <= 32'h00000000;
            slverr_q <= 1'h0;
        end
        else
        begin
            ack_q <= ack_d;
            prdata_q <= prdata_d;
            slverr_q <= slverr_d;
        end
    end

    assign pready = ack_q;
    assign prdata = prdata_q;
    assign pslverr = slverr_q;

    // A write lands only at the edge where the master sees pready.
    assign wrEn = psel & penable & ack_q & pwrite;

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            cfgRegs_d[i] = cfgRegs_q[i];
            if (wrEn & cfgHit[i])
            begin
                cfgRegs_d[i] = pwdata[7:0] & `BCV_CFG_WMASK;
            end
        end
        for (int j = 0; j < 2; j++)
        begin
            coreVolt_d[j] = coreVolt_q[j];
            if (wrEn & voltHit[j])
            begin
                coreVolt_d[j] = pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                cfgRegs_q[i] <= `BCV_CFG_RST;
            end
            for (int j = 0; j < 2; j++)
            begin
                coreVolt_q[j] <= `BCV_VOLT_RST;
            end
        end
        else
        begin
            cfgRegs_q <= cfgRegs_d;
            coreVolt_q <= coreVolt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Operating style per converter
    // ------------------------------------------------------------------------
    // The same decoder serves all three, the IO converter included.
    for (genvar g = 0; g < 3; g++)
    begin : gDecode
        bcv_mode_decode uDecode
        (
            .opSelect(bcv_pkg::bcv_op_sel_t'(cfgRegs_q[g][`BCV_OP_HI:`BCV_OP_LO])),
            .vregSleep(vregSleep[g]),
            .style(styleNext[g])
        );
    end

    // Registering the style keeps glitches off the analog mode lines.
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            style_d[i] = styleNext[i];
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                style_q[i] <= bcv_pkg::BCV_STY_SYNC;
            end
        end
        else
        begin
            style_q <= style_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs to the converters
    // ------------------------------------------------------------------------
    // The sense select is passed on as written; keeping it non-zero is up to software.
    assign ioConvOpSelect = cfgRegs_q[0][`BCV_OP_HI:`BCV_OP_LO];
    assign ioConvPulldownOff = cfgRegs_q[0][`BCV_PD_BIT];
    assign ioConvSenseSelect = cfgRegs_q[0][`BCV_SENSE_HI:`BCV_SENSE_LO];
    assign ioConvStyle = style_q[0];
    assign memConvOpSelect = cfgRegs_q[1][`BCV_OP_HI:`BCV_OP_LO];
    assign memConvPulldownOff = cfgRegs_q[1][`BCV_PD_BIT];
    assign memConvSenseSelect = cfgRegs_q[1][`BCV_SENSE_HI:`BCV_SENSE_LO];
    assign memConvStyle = style_q[1];
    assign periphConvOpSelect = cfgRegs_q[2][`BCV_OP_HI:`BCV_OP_LO];
    assign periphConvPulldownOff = cfgRegs_q[2][`BCV_PD_BIT];
    assign periphConvSenseSelect = cfgRegs_q[2][`BCV_SENSE_HI:`BCV_SENSE_LO];
    assign periphConvStyle = style_q[2];
    assign coreTwoSleepOnA = coreVolt_q[0][`BCV_SLEEP_BIT];
    assign coreTwoTargetCodeA = coreVolt_q[0][`BCV_CODE_HI:`BCV_CODE_LO];
    assign coreOneSleepOnA = coreVolt_q[1][`BCV_SLEEP_BIT];
    assign coreOneTargetCodeA = coreVolt_q[1][`BCV_CODE_HI:`BCV_CODE_LO];

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    sequence apbSetup;
        psel && !penable;
    endsequence
    sequence apbDone;
        psel && penable && pready;
    endsequence
    sequence ioCfgWrite;
        apbDone and (pwrite && wordIdx == (ADDR_W-2)'(`BCV_IDX_IO_CFG));
    endsequence
    sequence coreOneWrite;
        apbDone and (pwrite && wordIdx == (ADDR_W-2)'(`BCV_IDX_CORE_ONE_VA));
    endsequence

    // Every access ends two edges after its setup cycle.
    setup_to_ready_a: assert property (apbSetup ##1 (psel && penable) |=> pready)
        else $error("pready did not follow the access cycle.");
    unmapped_error_a: assert property (apbDone and !hit |-> pslverr)
        else $error("Unmapped access was not flagged.");
    reserved_read_a: assert property (
        apbDone and (!pwrite && |cfgHit) |-> prdata[31:8] == 24'h000000
            && prdata[`BCV_RSV_HI:`BCV_RSV_LO] == 2'h0)
        else $error("Reserved configuration bits read non-zero.");
    pulldown_write_a: assert property (
        ioCfgWrite |=> ioConvPulldownOff == $past(pwdata[`BCV_PD_BIT]))
        else $error("Pull-down control did not take the written bit.");
    sense_write_a: assert property (
        ioCfgWrite |=> ioConvSenseSelect == $past(pwdata[`BCV_SENSE_HI:`BCV_SENSE_LO]) ##1
            $stable(ioConvSenseSelect) || $past(wrEn))
        else $error("Sense select did not take the written value.");
    core_sleep_a: assert property (
        coreOneWrite |=> coreOneSleepOnA == $past(pwdata[`BCV_SLEEP_BIT]))
        else $error("Core sleep bit did not take the written value.");
    core_code_a: assert property (
        coreOneWrite |=> coreOneTargetCodeA == $past(pwdata[`BCV_CODE_HI:`BCV_CODE_LO]))
        else $error("Core target code did not take the written value.");
    io_forced_sleep_a: assert property (
        ioConvOpSelect == bcv_pkg::BCV_OP_SLEEP |=> ioConvStyle == bcv_pkg::BCV_STY_SLEEP)
        else $error("IO converter not in sleep for select 01.");
    for (genvar k = 0; k < 3; k++)
    begin : gStyleChk
        vreg_style_a: assert property (
            cfgRegs_q[k][`BCV_OP_HI:`BCV_OP_LO] == bcv_pkg::BCV_OP_FROM_VREG |=> style_q[k] ==
                ($past(vregSleep[k]) ? bcv_pkg::BCV_STY_SLEEP : bcv_pkg::BCV_STY_SYNC))
            else $error("Style does not follow the voltage register sleep bit.");
        forced_sleep_a: assert property (
            cfgRegs_q[k][`BCV_OP_HI:`BCV_OP_LO] == bcv_pkg::BCV_OP_SLEEP
                |=> style_q[k] == bcv_pkg::BCV_STY_SLEEP)
            else $error("Style not sleep for select 01.");
        forced_sync_auto_a: assert property (
            cfgRegs_q[k][`BCV_OP_HI] |=> style_q[k] ==
                ($past(cfgRegs_q[k][`BCV_OP_LO]) ? bcv_pkg::BCV_STY_AUTO : bcv_pkg::BCV_STY_SYNC))
            else $error("Style wrong for select 10 or 11.");
    end

endmodule

// ---- testbench/bcv_regs_tb.sv ----
// Self-checking testbench of the converter register bank.
`timescale 1ns/10ps
`include "bcv_consts.svh"

`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            n_mismatch++; \
            $display("[ERR] %0t got %0h expected %0h", $time, (g), (e)); \
        end \
    end

module bcv_regs_tb;

// ----------------------------------------------------------------------------
// Signals
// ----------------------------------------------------------------------------
typedef struct packed {logic [7:0] idx; logic [7:0] wdat; logic [7:0] rdat;} bcv_row_t;
logic clock = 1'h0;
logic nrst = 1'h0;
logic psel = 1'h0;
logic penable = 1'h0;
logic pwrite = 1'h0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h00000000;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic [2:0] vregSleep = 3'h0;
logic [1:0] ioOp, memOp, periphOp;
logic ioPd, memPd, periphPd;
logic [2:0] ioSense, memSense, periphSense;
logic [2:0] ioStyle, memStyle, periphStyle;
logic oneSleep, twoSleep;
logic [6:0] oneCode, twoCode;
int n_mismatch = 0;
int n_compared = 0;
// Reserved bits come back as zero; upper data bits are always written as ones.
bcv_row_t rows [7] = '{'{8'hA0, 8'hFF, 8'hE7}, '{8'hA1, 8'h5A, 8'h42},
    '{8'hA2, 8'h3C, 8'h24}, '{8'hA3, 8'hFF, 8'hFF}, '{8'hA4, 8'h00, 8'h00},
    '{8'hA3, 8'h7F, 8'h7F}, '{8'hA4, 8'h80, 8'h80}};

// Free-running 125 MHz clock.
always #4 clock = ~clock;

// Device under test.
bcv_regs #(.ADDR_W(12)) u_dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ioVregSleep(vregSleep[0]), .memVregSleep(vregSleep[1]),
    .periphVregSleep(vregSleep[2]), .ioConvOpSelect(ioOp), .ioConvPulldownOff(ioPd),
    .ioConvSenseSelect(ioSense), .ioConvStyle(ioStyle), .memConvOpSelect(memOp),
    .memConvPulldownOff(memPd), .memConvSenseSelect(memSense), .memConvStyle(memStyle),
    .periphConvOpSelect(periphOp), .periphConvPulldownOff(periphPd),
    .periphConvSenseSelect(periphSense), .periphConvStyle(periphStyle),
    .coreOneSleepOnA(oneSleep), .coreOneTargetCodeA(oneCode), .coreTwoSleepOnA(twoSleep),
    .coreTwoTargetCodeA(twoCode));

// ----------------------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------------------
// Expected one-hot style from the select field and the voltage sleep bit.
function automatic logic [2:0] expStyle(input logic [1:0] op, input logic s);
    case (op)
        2'h0: expStyle = s ? bcv_pkg::BCV_STY_SLEEP : bcv_pkg::BCV_STY_SYNC;
        2'h1: expStyle = bcv_pkg::BCV_STY_SLEEP;
        2'h2: expStyle = bcv_pkg::BCV_STY_SYNC;
        default: expStyle = bcv_pkg::BCV_STY_AUTO;
    endcase
endfunction

// Register image rebuilt from the converter control outputs.
function automatic logic [7:0] view(input logic [7:0] idx);
    case (idx)
        8'hA0: view = {ioOp, ioPd, 2'h0, ioSense};
        8'hA1: view = {memOp, memPd, 2'h0, memSense};
        8'hA2: view = {periphOp, periphPd, 2'h0, periphSense};
        8'hA3: view = {twoSleep, twoCode};
        8'hA4: view = {oneSleep, oneCode};
        default: view = 8'h00;
    endcase
endfunction

// Prints the counts and the verdict, then ends the run.
task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask

// One APB transfer; the request is held until pready is sampled high.
task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int i;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'h1;
    for (i = 0; i < 16; i++)
    begin
        @(posedge clock);
        if (pready === 1'h1)
            break;
    end
    if (i == 16)
    begin
        $display("[ERR] %0t no pready", $time);
        n_mismatch++;
        close_out();
    end
    else
    begin
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        pwdata <= ~wd;
        paddr <= ~paddr;
    end
endtask

// Mapped write, expected to be accepted.
task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    apb(1'h1, idx, wd, d, e);
    `CHK(e, 1'h0)
endtask

// Mapped read compared with an expected word.
task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic e;
    apb(1'h0, idx, 32'h00000000, d, e);
    `CHK(e, 1'h0)
    `CHK(d, exp)
endtask

// Reset image of all registers, at the ports and over the bus.
task automatic checkReset();
    logic [7:0] idx;
    logic [7:0] exp;
    for (int k = 0; k < 5; k++)
    begin
        idx = 8'hA0 + 8'(k);
        exp = (k < 3) ? `BCV_CFG_RST : `BCV_VOLT_RST;
        `CHK(view(idx), exp)
        rdchk(idx, {24'h000000, exp});
    end
    `CHK({ioStyle, memStyle, periphStyle}, {3{bcv_pkg::BCV_STY_SYNC}})
endtask

// ----------------------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------------------
initial
begin
    logic [31:0] d;
    logic e;
    repeat (16) @(posedge clock);
    nrst <= 1'h1;
    checkReset();
    // Ordinary cases: write with junk upper bits, read back, compare the ports.
    for (int k = 0; k < 7; k++)
    begin
        wr(rows[k].idx, {24'hFFFFFF, rows[k].wdat});
        rdchk(rows[k].idx, {24'h000000, rows[k].rdat});
        `CHK(view(rows[k].idx), rows[k].rdat)
    end
    // Every select code against both sleep levels; each converter senses another source.
    for (int op = 0; op < 4; op++)
    begin
        for (int s = 0; s < 2; s++)
        begin
            vregSleep <= {s[0], ~s[0], s[0]};
            wr(8'hA0, {24'h000000, op[1:0], 6'h01});
            wr(8'hA1, {24'h000000, op[1:0], 6'h02});
            wr(8'hA2, {24'h000000, op[1:0], 6'h04});
            repeat (2) @(posedge clock);
            `CHK(ioStyle, expStyle(op[1:0], s[0]))
            `CHK(memStyle, expStyle(op[1:0], ~s[0]))
            `CHK(periphStyle, expStyle(op[1:0], s[0]))
            `CHK({ioSense, memSense, periphSense}, 9'h054)
        end
    end
    // Unmapped accesses are refused and leave the bank untouched.
    apb(1'h1, 8'hA5, 32'h000000FF, d, e);
    `CHK({e, d}, 33'h100000000)
    apb(1'h0, 8'h00, 32'h00000000, d, e);
    `CHK({e, d}, 33'h100000000)
    rdchk(8'hA4, 32'h00000080);
    // A second reset in mid-run restores every reset value at once.
    vregSleep <= 3'h0;
    nrst <= 1'h0;
    repeat (2) @(posedge clock);
    `CHK({pready, pslverr, prdata}, 34'h0)
    `CHK(view(8'hA2), `BCV_CFG_RST)
    nrst <= 1'h1;
    checkReset();
    close_out();
end

endmodule
